// ===== core/cmbx_mailbox.sv
// Purpose: mailbox identifier/control words with apb access, rx update, tx frame out
// Assumes: apb slave with no wait states; rx and tx ports synchronous to pclk
//          read word captured at the end of setup, so a write landing on that edge reads old
// Notes:   contents follow reset to zero although real ram would be undefined
//
// Contract
// - standard identifier held in identifier word bits 14 to 4
// - identifier bit 3 is frame type: 0 data, 1 remote
// - configuration 001 with auto answer: remote reception leaves frame type unchanged
// - identifier bit 2 selects format: 0 standard, 1 extended
// - 18-bit extension: top two in identifier bits 1..0, rest next word
// - reception with acceptance masking replaces stored identifier by received one
// - mailboxes 0 and 31 receive only; others per configuration
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/100ps
module cmbx_mailbox #(
  parameter int unsigned NUM_MBOX = cmbx_pkg::CMBX_NUM_MBOX
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [13:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // receive engine
  input  wire logic                 rx_valid,
  input  wire logic [4:0]           rx_mbox,
  input  wire logic                 rx_mask_en,
  input  wire cmbx_pkg::cmbx_frame_t rx_frame,
  // transmit engine
  input  wire logic                 tx_req,
  input  wire logic [4:0]           tx_mbox,
  output logic                      tx_valid,
  output logic                      tx_refused,
  output cmbx_pkg::cmbx_tx_t        tx_frame
);
  import cmbx_pkg::*;

  if (NUM_MBOX != 32) begin : g_num_check
    $error("cmbx_mailbox: only 32 mailboxes are supported");
  end

  logic [15:0] idw_q   [NUM_MBOX];
  logic [15:0] extlo_q [NUM_MBOX];
  logic [15:0] ctrl_q  [NUM_MBOX];

  // decode: returns {hit, word select, mailbox}
  function automatic logic [7:0] cmbx_decode(input logic [11:0] idx);
    logic [11:0] rel;
    logic [4:0]  ofs;
    rel = idx - CMBX_MBOX_BASE;
    ofs = rel[4:0];
    cmbx_decode = 8'h00;
    if (idx >= CMBX_MBOX_BASE && rel < 12'(NUM_MBOX) * CMBX_MBOX_PITCH) begin
      if (ofs == CMBX_OFS_IDW[4:0])   cmbx_decode = {1'b1, 2'h0, rel[9:5]};
      if (ofs == CMBX_OFS_EXTLO[4:0]) cmbx_decode = {1'b1, 2'h1, rel[9:5]};
      if (ofs == CMBX_OFS_CTRL[4:0])  cmbx_decode = {1'b1, 2'h2, rel[9:5]};
    end
  endfunction : cmbx_decode

  function automatic logic rx_only(input logic [4:0] mb);
    rx_only = (mb == CMBX_RX_ONLY_LO) || (mb == CMBX_RX_ONLY_HI);
  endfunction : rx_only

  logic [7:0]  dec;
  logic        hit;
  logic [1:0]  wsel;
  logic [4:0]  wmb;
  logic        acc;
  logic        full_word;
  logic        wr_ok;

  assign dec       = cmbx_decode(paddr[13:2]);
  assign hit       = dec[7];
  assign wsel      = dec[6:5];
  assign wmb       = dec[4:0];
  assign acc       = psel && penable;
  assign full_word = (pstrb[1:0] == 2'b11);
  assign pready    = 1'b1;
  // writes without both low byte lanes (pstrb[1:0] not 11) are refused with an error and change nothing
  assign pslverr   = acc && (!hit || (pwrite && !full_word));
  assign wr_ok     = acc && pwrite && hit && full_word;

  // rx frame-type handling
  logic [2:0]  rx_mbc;
  logic        rx_atx;
  logic        rx_keep_rtr;
  assign rx_mbc      = ctrl_q[rx_mbox][CMBX_MBC_MSB:CMBX_MBC_LSB];
  assign rx_atx      = ctrl_q[rx_mbox][CMBX_ATX_POS];
  assign rx_keep_rtr = (rx_mbc == CMBX_MBC_RXATX) && rx_atx;

  // identifier word; reception wins over a same-cycle software write to that mailbox on the fields it updates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_MBOX; i++) idw_q[i] <= CMBX_WORD_RST;
    end else begin
      if (wr_ok && wsel == 2'h0) idw_q[wmb] <= pwdata[15:0];
      if (rx_valid) begin
        if (rx_mask_en) begin
          idw_q[rx_mbox][CMBX_STD_MSB:CMBX_STD_LSB] <= rx_frame.standard_identifier;
          idw_q[rx_mbox][CMBX_IDE_POS]              <= rx_frame.extended_format_flag;
          idw_q[rx_mbox][CMBX_EXTHI_MSB:0]          <= rx_frame.identifier_extension[17:16];
        end
        if (!rx_keep_rtr) idw_q[rx_mbox][CMBX_RTR_POS] <= rx_frame.remote_frame_flag;
      end
    end
  end

  // extension low word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_MBOX; i++) extlo_q[i] <= CMBX_WORD_RST;
    end else begin
      if (wr_ok && wsel == 2'h1) extlo_q[wmb] <= pwdata[15:0];
      if (rx_valid && rx_mask_en && rx_frame.extended_format_flag) begin
        extlo_q[rx_mbox] <= rx_frame.identifier_extension[15:0];
      end
    end
  end

  // control word; compare match is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_MBOX; i++) ctrl_q[i] <= CMBX_WORD_RST;
    end else if (wr_ok && wsel == 2'h2) begin
      ctrl_q[wmb] <= {1'b0, pwdata[CMBX_CCM_POS-1:0]};
    end
  end

  // read word taken at the setup edge so prdata leaves a flip-flop yet needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && hit) begin
      unique case (wsel)
        2'h0:    prdata <= {16'h0000, idw_q[wmb]};
        2'h1:    prdata <= {16'h0000, extlo_q[wmb]};
        default: prdata <= {16'h0000, ctrl_q[wmb]};
      endcase
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // transmit side
  logic [15:0] tx_idw;
  logic [28:0] tx_id;
  logic        tx_allow;
  assign tx_idw   = idw_q[tx_mbox];
  assign tx_allow = !rx_only(tx_mbox) &&
                    (ctrl_q[tx_mbox][CMBX_MBC_MSB:CMBX_MBC_LSB] == CMBX_MBC_TX);

  cmbx_id_format u_fmt (
    .standard_identifier  (tx_idw[CMBX_STD_MSB:CMBX_STD_LSB]),
    .identifier_extension ({tx_idw[CMBX_EXTHI_MSB:0], extlo_q[tx_mbox]}),
    .extended_format_flag (tx_idw[CMBX_IDE_POS]),
    .frame_id             (tx_id)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid   <= 1'b0;
      tx_refused <= 1'b0;
      tx_frame   <= '0;
    end else begin
      tx_valid   <= tx_req && tx_allow;
      tx_refused <= tx_req && !tx_allow;
      if (tx_req && tx_allow) begin
        tx_frame.frame_id             <= tx_id;
        tx_frame.remote_frame_flag    <= tx_idw[CMBX_RTR_POS];
        tx_frame.extended_format_flag <= tx_idw[CMBX_IDE_POS];
      end
    end
  end

  // checks
  rx_only_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_req && rx_only(tx_mbox) |=> !tx_valid && tx_refused)
    else $error("transmit granted from a receive-only mailbox");
  tx_id_form_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_req && tx_allow && tx_idw[CMBX_IDE_POS] |=>
      tx_frame.frame_id == {$past(tx_idw[CMBX_STD_MSB:CMBX_STD_LSB]), $past(tx_idw[1:0]),
                            $past(extlo_q[tx_mbox])})
    else $error("extended identifier formed wrongly");
  rx_std_id_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && rx_mask_en |=>
      idw_q[$past(rx_mbox)][CMBX_STD_MSB:CMBX_STD_LSB] == $past(rx_frame.standard_identifier))
    else $error("received standard identifier not stored");
  rx_ext_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && rx_mask_en && rx_frame.extended_format_flag |=>
      extlo_q[$past(rx_mbox)] == $past(rx_frame.identifier_extension[15:0]))
    else $error("received extension low half not stored");
  rtr_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && rx_keep_rtr && !(wr_ok && wsel == 2'h0 && wmb == rx_mbox) |=>
      idw_q[$past(rx_mbox)][CMBX_RTR_POS] == $past(idw_q[rx_mbox][CMBX_RTR_POS]))
    else $error("frame type changed under auto answer");
  rtr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && !rx_keep_rtr |=>
      idw_q[$past(rx_mbox)][CMBX_RTR_POS] == $past(rx_frame.remote_frame_flag))
    else $error("frame type not taken from reception");
  ccm_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && hit && wsel == 2'h2 |-> !prdata[CMBX_CCM_POS])
    else $error("compare match bit reads set");
  word_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && hit && !full_word && !rx_valid |->
      pslverr ##1 (idw_q[$past(wmb)] == $past(idw_q[wmb]) &&
                   extlo_q[$past(wmb)] == $past(extlo_q[wmb]) &&
                   ctrl_q[$past(wmb)] == $past(ctrl_q[wmb])))
    else $error("partial write not refused");
  std_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && wsel == 2'h0 && !rx_valid |=>
      idw_q[$past(wmb)][CMBX_STD_MSB:CMBX_STD_LSB] == $past(pwdata[14:4]))
    else $error("standard identifier write lost");

  tx_ext_c:   cover property (@(posedge pclk) tx_valid && tx_frame.extended_format_flag);
  rx_keep_c:  cover property (@(posedge pclk) rx_valid && rx_keep_rtr);
  tx_refuse_c: cover property (@(posedge pclk) tx_refused);
endmodule : cmbx_mailbox

// ===== core/cmbx_pkg.sv
// Purpose: constants and carriers for the can mailbox identifier fields
// Assumes: apb word index = printed halfword offset, byte address = 4 * index
// Notes:   only identifier, extension and control words are modelled
package cmbx_pkg;
  localparam int unsigned      CMBX_NUM_MBOX   = 32;
  localparam logic [11:0]      CMBX_MBOX_BASE  = 12'h100;
  localparam logic [11:0]      CMBX_MBOX_PITCH = 12'h020;
  localparam logic [11:0]      CMBX_OFS_IDW    = 12'h000;
  localparam logic [11:0]      CMBX_OFS_EXTLO  = 12'h002;
  localparam logic [11:0]      CMBX_OFS_CTRL   = 12'h004;
  // identifier word layout
  localparam int unsigned      CMBX_STD_MSB    = 14;
  localparam int unsigned      CMBX_STD_LSB    = 4;
  localparam int unsigned      CMBX_RTR_POS    = 3;
  localparam int unsigned      CMBX_IDE_POS    = 2;
  localparam int unsigned      CMBX_EXTHI_MSB  = 1;
  // control word layout
  localparam int unsigned      CMBX_CCM_POS    = 15;
  localparam int unsigned      CMBX_ATX_POS    = 12;
  localparam int unsigned      CMBX_MBC_MSB    = 10;
  localparam int unsigned      CMBX_MBC_LSB    = 8;
  localparam logic [2:0]       CMBX_MBC_TX     = 3'h0;
  localparam logic [2:0]       CMBX_MBC_RXATX  = 3'h1;
  localparam logic [15:0]      CMBX_WORD_RST   = 16'h0000;
  localparam logic [4:0]       CMBX_RX_ONLY_LO = 5'h00;
  localparam logic [4:0]       CMBX_RX_ONLY_HI = 5'h1f;

  typedef struct packed {
    logic [10:0] standard_identifier;
    logic [17:0] identifier_extension;
    logic        remote_frame_flag;
    logic        extended_format_flag;
  } cmbx_frame_t;

  typedef struct packed {
    logic [28:0] frame_id;
    logic        remote_frame_flag;
    logic        extended_format_flag;
  } cmbx_tx_t;
endpackage : cmbx_pkg

// ===== core/cmbx_id_format.sv
// Purpose: build the on-wire identifier from the stored fields
// Assumes: standard format uses the 11 bits in the top of the 29-bit field
// Notes:   purely combinational
`timescale 1ns/100ps
module cmbx_id_format (
  // stored fields
  input  wire logic [10:0] standard_identifier,
  input  wire logic [17:0] identifier_extension,
  input  wire logic        extended_format_flag,
  // formed identifier
  output logic      [28:0] frame_id
);
  import cmbx_pkg::*;
  // extension is zeroed in standard format so compares stay clean
  assign frame_id = extended_format_flag ? {standard_identifier, identifier_extension}
                                         : {standard_identifier, 18'h00000};
endmodule : cmbx_id_format

// ===== testbench/cmbx_can_node.sv
// Purpose: far-side can node model that hands receptions to the mailbox
// Assumes: one reception per pulse, synchronous to pclk
// Notes:   released fields go to inverted values so stale data never passes
`timescale 1ns/100ps
module cmbx_can_node (
  // clock
  input  wire logic             pclk,
  // reception toward the mailbox
  output logic                  rx_valid,
  output logic [4:0]            rx_mbox,
  output logic                  rx_mask_en,
  output cmbx_pkg::cmbx_frame_t rx_frame
);
  import cmbx_pkg::*;
  initial begin
    rx_valid   = 1'b0;
    rx_mbox    = 5'h00;
    rx_mask_en = 1'b0;
    rx_frame   = '0;
  end
  task automatic send(input logic [4:0] mb, input logic m, input cmbx_frame_t f);
    @(posedge pclk);
    rx_valid   <= 1'b1;
    rx_mbox    <= mb;
    rx_mask_en <= m;
    rx_frame   <= f;
    @(posedge pclk);
    rx_valid   <= 1'b0;
    rx_mbox    <= ~mb;
    rx_mask_en <= ~m;
    rx_frame   <= ~f;
  endtask : send
endmodule : cmbx_can_node

// ===== testbench/test_cmbx_mailbox.sv
// Purpose: self-checking bench for the can mailbox identifier fields
// Assumes: zero-wait apb slave, tx answer one cycle after the request
// Notes:   words reset to zero here, so reset reads expect zero
`timescale 1ns/100ps
module test_cmbx_mailbox;
  import cmbx_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, tx_req = 1'b0, pready, pslverr, erv;
  logic        rx_valid, rx_mask_en, tx_valid, tx_refused;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [3:0]  pstrb = 4'hf;
  logic [4:0]  rx_mbox, tx_mbox = 5'h00;
  cmbx_frame_t rx_frame;
  cmbx_tx_t    tx_frame;
  int          err_total = 0, compares = 0;
  always #5 pclk = ~pclk;
  cmbx_mailbox DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .rx_valid, .rx_mbox, .rx_mask_en, .rx_frame, .tx_req,
    .tx_mbox, .tx_valid, .tx_refused, .tx_frame);
  cmbx_can_node node (.pclk, .rx_valid, .rx_mbox, .rx_mask_en, .rx_frame);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask : chk
  task results;
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [4:0] mb, input logic [11:0] k,
                     input logic [15:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {CMBX_MBOX_BASE + CMBX_MBOX_PITCH * mb + k, 2'b00};
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      results();
    end
  endtask : apb
  task automatic tx(input logic [4:0] mb, input logic ok, input cmbx_tx_t f);
    @(posedge pclk);
    tx_req  <= 1'b1;
    tx_mbox <= mb;
    @(posedge pclk);
    tx_req  <= 1'b0;
    tx_mbox <= ~mb;
    @(negedge pclk);
    chk("tx_valid", tx_valid, ok);
    chk("tx_refused", tx_refused, !ok);
    if (ok) chk("tx_frame", tx_frame, f);
  endtask : tx
  task automatic reset_read;
    apb(1'b0, 5'd1, CMBX_OFS_IDW, 16'h0000);
    chk("reset id word", rdv, 32'h0);
  endtask : reset_read
  task automatic id_fields;
    // top bit kept zero by software
    apb(1'b1, 5'd2, CMBX_OFS_IDW, 16'h5a5e);
    chk("write err", erv, 1'b0);
    apb(1'b1, 5'd2, CMBX_OFS_EXTLO, 16'hbeef);
    apb(1'b0, 5'd2, CMBX_OFS_IDW, 16'h0000);
    chk("std id", rdv[14:4], 11'h5a5);
    chk("frame type", rdv[3], 1'b1);
    chk("format", rdv[2], 1'b1);
    chk("ext hi", rdv[1:0], 2'b10);
    apb(1'b0, 5'd2, CMBX_OFS_EXTLO, 16'h0000);
    chk("ext lo", rdv, 32'hbeef);
  endtask : id_fields
  task automatic partial_write;
    pstrb <= 4'h1;
    apb(1'b1, 5'd2, CMBX_OFS_EXTLO, 16'h1234);
    chk("partial err", erv, 1'b1);
    pstrb <= 4'hf;
    apb(1'b0, 5'd2, CMBX_OFS_EXTLO, 16'h0000);
    chk("partial kept", rdv, 32'hbeef);
  endtask : partial_write
  task automatic tx_cases;
    apb(1'b1, 5'd2, CMBX_OFS_CTRL, 16'h0000);
    tx(5'd2, 1'b1, {11'h5a5, 18'h2beef, 1'b1, 1'b1});
    apb(1'b1, 5'd2, CMBX_OFS_IDW, 16'h5a52);
    tx(5'd2, 1'b1, {11'h5a5, 18'h00000, 1'b0, 1'b0});
    tx(5'd0, 1'b0, '0);
    tx(5'd31, 1'b0, '0);
    apb(1'b1, 5'd2, CMBX_OFS_CTRL, 16'h1100);
    tx(5'd2, 1'b0, '0);
  endtask : tx_cases
  task automatic rx_masked;
    // masked reception overwrites the stored identifier
    node.send(5'd3, 1'b1, {11'h123, 18'h2abcd, 1'b0, 1'b1});
    apb(1'b0, 5'd3, CMBX_OFS_IDW, 16'h0000);
    chk("rx id word", rdv, 32'h1236);
    apb(1'b0, 5'd3, CMBX_OFS_EXTLO, 16'h0000);
    chk("rx ext lo", rdv, 32'habcd);
  endtask : rx_masked
  task automatic auto_answer;
    // auto answer must not flip the frame type
    apb(1'b1, 5'd4, CMBX_OFS_CTRL, 16'h1100);
    node.send(5'd4, 1'b1, {11'h055, 18'h00000, 1'b1, 1'b0});
    apb(1'b0, 5'd4, CMBX_OFS_IDW, 16'h0000);
    chk("auto remote", rdv, 32'h0550);
    apb(1'b1, 5'd4, CMBX_OFS_CTRL, 16'h0000);
    node.send(5'd4, 1'b1, {11'h055, 18'h00000, 1'b1, 1'b0});
    apb(1'b0, 5'd4, CMBX_OFS_IDW, 16'h0000);
    chk("remote set", rdv, 32'h0558);
  endtask : auto_answer
  task automatic unmapped;
    apb(1'b0, 5'd0, 12'hf00, 16'h0000);
    chk("unmapped err", erv, 1'b1);
    chk("unmapped data", rdv, 32'h0);
  endtask : unmapped
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reset_read();
    id_fields();
    partial_write();
    tx_cases();
    rx_masked();
    auto_answer();
    unmapped();
    results();
  end
endmodule : test_cmbx_mailbox
